// ### sync_serial_mode_options.v
// Functional notes
// R1 - a polarity bit picks which clock edge launches and samples data.
// R2 - bit order is lsb first when the order bit is 0, msb first when 1.
// R3 - with continuous receive on, reading rx buffer re-arms reception.
// R4 - two clock pin outputs exist and a select bit picks which is driven; the code drives the second only with MODE_CLKPIN and MODE_ALTPIN both set.
// R5 - the pin selection acts only when the internal clock is in use.
// R6 - the data logic bit inverts tx data on write and rx data on read.
// R7 - the io polarity bit inverts the output pin and the sampled input.
// R8 - before a transfer the output pin idles high, or floats if open drain; with the io polarity bit set the code idles it low and driven.
// R9 - clock pin drives out on internal clock, is an input on external.
// R10 - serial input pin is data input when its direction bit is 0; with rx disabled the code marks it free as port instead.
// R11 - handshake pin is cts in, rts out, or plain port by two bits.
// R12 - every frame carries exactly eight data bits.
// R13 - internal transfer clock is the source clock over 2(n+1).
// R14 - reception starts only with rx and tx enabled and tx data loaded.
// R15 - overrun overwrites the buffer, flags error, rx request unchanged.
// R16 - data is sampled on the edge opposite the launch edge.
// R17 - an external clock gives eight cycles per frame and idles between.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_regs.vh"
module sync_serial_mode_options (
    input  wire        pclk,               // system clock, 125 MHz
    input  wire        presetn,            // async reset, low
    input  wire        psel,               // apb select
    input  wire        penable,            // apb enable
    input  wire        pwrite,             // apb direction
    input  wire [11:0] paddr,              // apb byte address
    input  wire [31:0] pwdata,             // apb write data
    output reg  [31:0] prdata,             // apb read data
    output reg         pready,             // apb ready
    output reg         pslverr,            // apb error
    input  wire        peripheral_clock_source, // divider tick enable level
    output reg         serial_out_pin_o,   // serial data out
    output reg         serial_out_pin_oe,  // serial data enable
    input  wire        serial_in_pin,      // serial data in
    input  wire        transfer_clock_pin_i,  // clock pin in
    output reg         transfer_clock_pin_o,  // clock pin out
    output reg         transfer_clock_pin_oe, // clock pin enable
    output reg         alt_clock_pin_o,    // second clock pin out
    output reg         alt_clock_pin_oe,   // second clock pin enable
    input  wire        handshake_pin_i,    // cts input
    output reg         handshake_pin_o,    // rts output
    output reg         handshake_pin_oe,   // handshake enable
    output reg         gpio_in_valid,      // rx pin free as port
    output reg         irq                 // level interrupt
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg [`MODE_WIDTH-1:0] mode;
    reg [2:0]             ctrl;
    reg [7:0]             brg;
    reg [7:0]             txbuf;
    reg                   txfull;
    reg [7:0]             rxbuf;
    reg                   rxfull;
    reg [`INT_WIDTH-1:0]  int_stat;
    reg [`INT_WIDTH-1:0]  int_en;
    reg                   rx_armed;
    reg                   busy;
    reg                   tclk;
    reg [7:0]             div_cnt;
    reg                   load;
    reg [2:0]             rx_sync;
    reg [2:0]             ck_sync;
    reg [2:0]             cts_sync;
    reg                   ck_stable;
    reg                   rx_stable;
    reg                   cts_stable;
    reg                   ck_prev;
    reg [`INT_WIDTH-1:0]  next_int;
    wire                  tx_bit;
    wire [7:0]            rx_data;
    wire                  done;
    wire                  ext = mode[`MODE_EXTCLK];
    wire                  pol = mode[`MODE_CLKPOL];
    wire                  wr  = psel & penable & pwrite & pready;
    wire                  rd  = psel & penable & ~pwrite & pready;
    wire                  rxbuf_read = rd && paddr == `OFF_RXBUF;
    // ------------------------------------------------------------------
    // pin synchronisers: change accepted when stages two and three agree
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sync    <= 3'h7;
            ck_sync    <= 3'h7;
            cts_sync   <= 3'h7;
            rx_stable  <= 1'b1;
            ck_stable  <= 1'b1;
            cts_stable <= 1'b1;
        end else begin
            rx_sync  <= {rx_sync[1:0], serial_in_pin};
            ck_sync  <= {ck_sync[1:0], transfer_clock_pin_i};
            cts_sync <= {cts_sync[1:0], handshake_pin_i};
            if (rx_sync[1] == rx_sync[2])
                rx_stable <= rx_sync[2];
            if (ck_sync[1] == ck_sync[2])
                ck_stable <= ck_sync[2];
            if (cts_sync[1] == cts_sync[2])
                cts_stable <= cts_sync[2];
        end
    end
    // ------------------------------------------------------------------
    // transfer clock generation and edge detection
    // ------------------------------------------------------------------
    // tclk idles at the level given by polarity: high when pol is 0
    wire idle_lvl = ~pol;
    wire cur_clk  = ext ? ck_stable : tclk;
    // leaving idle level launches, returning to it samples
    wire launch   = busy && ck_prev == idle_lvl && cur_clk != idle_lvl;
    wire sample   = busy && ck_prev != idle_lvl && cur_clk == idle_lvl;
    wire cts_ok   = mode[`MODE_HSDIS] | mode[`MODE_RTSSEL] | ~cts_stable;
    wire ck_idle  = ~ext | (ck_stable == idle_lvl);
    wire start    = ~busy & ~load & ctrl[`CTRL_TXEN] & txfull & cts_ok &
                    ck_idle & mode[`MODE_SYNC];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tclk    <= 1'b1;
            div_cnt <= 8'h00;
            ck_prev <= 1'b1;
        end else begin
            ck_prev <= cur_clk;
            if (!busy || ext) begin
                tclk    <= idle_lvl;
                div_cnt <= 8'h00;
            end else if (peripheral_clock_source) begin
                // half period is n+1 source ticks: see R13
                if (div_cnt == brg) begin
                    div_cnt <= 8'h00;
                    tclk    <= ~tclk;
                end else begin
                    div_cnt <= div_cnt + 8'h01;
                end
            end
        end
    end
    // ------------------------------------------------------------------
    // shift engine
    // ------------------------------------------------------------------
    sync_serial_shifter u_shift (
        .pclk      (pclk),
        .presetn   (presetn),
        .load      (load),
        .load_data (txbuf),
        .msb_first (mode[`MODE_MSB]),
        .launch    (launch),            // see R1
        .sample    (sample),            // see R16
        .rx_bit    (rx_stable ^ mode[`MODE_IOINV]), // see R7
        .tx_bit    (tx_bit),
        .rx_data   (rx_data),
        .done      (done)
    );
    // ------------------------------------------------------------------
    // apb slave, buffers, flags
    // ------------------------------------------------------------------
    always @* begin
        next_int = int_stat;
        if (wr && paddr == `OFF_INTCLR)
            next_int = int_stat & ~pwdata[`INT_WIDTH-1:0];
        // hardware set wins over software clear
        if (load)
            next_int[`INT_TXLOAD] = 1'b1;
        if (done) begin
            next_int[`INT_TXDONE] = 1'b1;
            if (rx_armed && rxfull && !rxbuf_read)
                next_int[`INT_OVR] = 1'b1;    // see R15
            else if (rx_armed)
                next_int[`INT_RX] = 1'b1;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode     <= {`MODE_WIDTH{1'b0}};
            ctrl     <= 3'h0;
            brg      <= 8'h00;
            txbuf    <= 8'h00;
            txfull   <= 1'b0;
            rxbuf    <= 8'h00;
            rxfull   <= 1'b0;
            int_stat <= {`INT_WIDTH{1'b0}};
            int_en   <= {`INT_WIDTH{1'b0}};
            rx_armed <= 1'b0;
            busy     <= 1'b0;
            load     <= 1'b0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h00000000;
        end else begin
            int_stat <= next_int;
            load     <= start;
            pready   <= psel & ~penable;
            pslverr  <= 1'b0;
            if (start) begin
                busy   <= 1'b1;
                txfull <= 1'b0;
                // see R14
                if (ctrl[`CTRL_RXEN])
                    rx_armed <= 1'b1;
            end
            if (done) begin
                busy   <= 1'b0;
                if (rx_armed) begin
                    rxbuf  <= rx_data;          // see R15
                    rxfull <= 1'b1;
                    if (!mode[`MODE_CONTRX])
                        rx_armed <= 1'b0;
                end
            end
            if (psel && !penable && !pwrite) begin
                case (paddr)
                `OFF_MODE:    prdata <= {17'h00000, mode};
                `OFF_CTRL:    prdata <= {29'h0, ctrl};
                `OFF_BRG:     prdata <= {24'h0, brg};
                // see R6
                `OFF_RXBUF:   prdata <= {24'h0, rxbuf ^
                                 {8{mode[`MODE_DATINV]}}};
                `OFF_STATUS:  prdata <= {27'h0, busy, rxfull, 1'b0,
                                 txfull, rx_armed};
                `OFF_INTSTAT: prdata <= {28'h0, int_stat};
                `OFF_INTEN:   prdata <= {28'h0, int_en};
                default:      prdata <= 32'h00000000;
                endcase
            end
            if (rxbuf_read) begin
                rxfull <= 1'b0;
                if (mode[`MODE_CONTRX])
                    rx_armed <= ctrl[`CTRL_RXEN]; // see R3
            end
            if (wr) begin
                case (paddr)
                `OFF_MODE:   mode  <= pwdata[`MODE_WIDTH-1:0];
                `OFF_CTRL:   ctrl  <= pwdata[2:0];
                `OFF_BRG:    brg   <= pwdata[7:0];
                `OFF_TXBUF: begin
                    // see R6
                    txbuf  <= pwdata[7:0] ^ {8{mode[`MODE_DATINV]}};
                    txfull <= 1'b1;
                end
                `OFF_INTEN:  int_en <= pwdata[`INT_WIDTH-1:0];
                default: ;
                endcase
            end
        end
    end
    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin_o      <= 1'b1;
            serial_out_pin_oe     <= 1'b0;
            transfer_clock_pin_o  <= 1'b1;
            transfer_clock_pin_oe <= 1'b0;
            alt_clock_pin_o       <= 1'b1;
            alt_clock_pin_oe      <= 1'b0;
            handshake_pin_o       <= 1'b1;
            handshake_pin_oe      <= 1'b0;
            gpio_in_valid         <= 1'b0;
            irq                   <= 1'b0;
        end else begin
            irq <= |(int_stat & int_en);
            // idle high, or low with io polarity set; open drain releases only a high line: see R8
            serial_out_pin_o  <= (busy ? tx_bit : 1'b1) ^ mode[`MODE_IOINV];
            serial_out_pin_oe <= mode[`MODE_SYNC] &
                (~mode[`MODE_OPENDR] |
                 ~((busy ? tx_bit : 1'b1) ^ mode[`MODE_IOINV])); // see R7
            transfer_clock_pin_o <= tclk;
            alt_clock_pin_o      <= tclk;
            // see R9 R4 R5
            transfer_clock_pin_oe <= mode[`MODE_SYNC] & ~ext &
                ~(mode[`MODE_CLKPIN] & mode[`MODE_ALTPIN]);
            alt_clock_pin_oe <= mode[`MODE_SYNC] & ~ext &
                mode[`MODE_CLKPIN] & mode[`MODE_ALTPIN];
            // see R11
            handshake_pin_o  <= ~(ctrl[`CTRL_RXEN] & ~rxfull);
            handshake_pin_oe <= ~mode[`MODE_HSDIS] & mode[`MODE_RTSSEL];
            // see R10
            gpio_in_valid <= ~mode[`MODE_RXDIR] & ~ctrl[`CTRL_RXEN];
        end
    end
endmodule
`default_nettype wire

// ### sync_serial_mode_options_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_regs.vh"
module sync_serial_mode_options_checker (
    input wire logic        pclk,                  // clock
    input wire logic        presetn,               // reset, low
    input wire logic        psel,                  // apb select
    input wire logic        penable,               // apb enable
    input wire logic        pwrite,                // apb direction
    input wire logic [11:0] paddr,                 // apb address
    input wire logic [31:0] pwdata,                // apb write data
    input wire logic        pready,                // apb ready
    input wire logic        pslverr,               // apb error
    input wire logic        serial_out_pin_o,      // data out
    input wire logic        serial_out_pin_oe,     // data enable
    input wire logic        transfer_clock_pin_o,  // clock out
    input wire logic        transfer_clock_pin_oe, // clock enable
    input wire logic        alt_clock_pin_oe,      // alt clock enable
    input wire logic        handshake_pin_oe,      // handshake enable
    input wire logic        irq                    // interrupt
);
    logic [14:0] mode_q;
    logic [7:0]  brg_q;
    logic [1:0]  quiet;
    logic [8:0]  half_cnt;
    logic        clk_prev;
    logic        tx_seen;
    wire         wr = psel & penable & pready & pwrite;
    wire         mwr = wr && paddr == `OFF_MODE;
    // pins may lag a mode write by a cycle or two, so wait until settled
    wire         settled = quiet == 2'd3;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 15'h0000;
            brg_q <= 8'h00;
            quiet <= 2'd0;
            half_cnt <= 9'h000;
            clk_prev <= 1'b1;
            tx_seen <= 1'b0;
        end else begin
            if (mwr) mode_q <= pwdata[14:0];
            if (wr && paddr == `OFF_BRG) brg_q <= pwdata[7:0];
            if (wr && paddr == `OFF_TXBUF) tx_seen <= 1'b1;
            quiet <= mwr ? 2'd0 : quiet + {1'b0, ~&quiet};
            clk_prev <= transfer_clock_pin_o;
            half_cnt <= (transfer_clock_pin_o != clk_prev) ? 9'h000 :
                        half_cnt + {8'h00, ~&half_cnt};
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_setup; psel && !penable; endsequence
    sequence apb_access; psel && penable && pready; endsequence
    ready_a: assert property (apb_setup |=> pready)
        else $error("no ready after setup");
    ready_once_a: assert property (apb_setup ##1 apb_access |=> !pready)
        else $error("ready held too long");
    no_error_a: assert property (pready |-> !pslverr)
        else $error("error response");
    irq_mask_a: assert property (wr && paddr == `OFF_INTEN &&
        pwdata[3:0] == 4'h0 |=> ##1 (!irq) [*3])
        else $error("masked interrupt raised");
    clk_out_a: assert property (settled && mode_q[`MODE_SYNC] &&
        !mode_q[`MODE_EXTCLK] && !mode_q[`MODE_CLKPIN] |-> transfer_clock_pin_oe)
        else $error("clock pin not driven");
    clk_in_a: assert property (settled && mode_q[`MODE_EXTCLK]
        |-> !transfer_clock_pin_oe) else $error("clock pin driven");
    alt_quiet_a: assert property (settled && mode_q[`MODE_EXTCLK]
        |-> !alt_clock_pin_oe) else $error("alt clock pin driven");
    hshake_dir_a: assert property (settled &&
        (mode_q[`MODE_HSDIS] || !mode_q[`MODE_RTSSEL]) |-> !handshake_pin_oe)
        else $error("handshake pin driven");
    idle_line_a: assert property (settled && mode_q[`MODE_SYNC] &&
        !tx_seen |-> (mode_q[`MODE_OPENDR] ? !serial_out_pin_oe :
        serial_out_pin_o == !mode_q[`MODE_IOINV]))
        else $error("data line not idle");
    half_period_a: assert property (settled &&
        !mode_q[`MODE_EXTCLK] && transfer_clock_pin_o != clk_prev
        |-> half_cnt >= {1'b0, brg_q}) else $error("clock half too short");
endmodule
bind sync_serial_mode_options sync_serial_mode_options_checker u_chk (.*);
`default_nettype wire

// ### sync_serial_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sync_serial_partner (
    input  wire logic       pclk,      // clock
    input  wire logic       presetn,   // reset, low
    input  wire logic       start,     // arm a frame
    input  wire logic       pol,       // clock polarity
    input  wire logic       msb,       // bit order
    input  wire logic       ext,       // partner makes the clock
    input  wire logic [7:0] tx_byte,   // byte to send
    input  wire logic       sclk_dev,  // clock from device
    input  wire logic       sdata_dev, // data from device
    output var  logic       ext_clk,   // clock to device
    output var  logic       sdata,     // data to device
    output var  logic [7:0] rx_byte,   // byte received
    output var  logic [4:0] edges      // clock edges seen
);
    logic       prev;
    logic [2:0] idx;
    logic [5:0] hc;
    logic [4:0] togs;
    wire        sclk = ext ? ext_clk : sclk_dev;
    wire  [2:0] bi = msb ? 3'd7 - idx : idx;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'b1;
            idx <= 3'd0;
            hc <= 6'd0;
            togs <= 5'd0;
            ext_clk <= 1'b1;
            sdata <= 1'b1;
            rx_byte <= 8'h00;
            edges <= 5'd0;
        end else begin
            prev <= sclk;
            if (sclk != prev) begin
                edges <= edges + 5'd1;
                if (sclk == pol) begin
                    sdata <= tx_byte[bi];
                end else begin
                    rx_byte[bi] <= sdata_dev;
                    idx <= idx + 3'd1;
                    // released line flips so a stale bit cannot pass
                    if (idx == 3'd7) sdata <= ~sdata;
                end
            end
            if (togs != 5'd0) begin
                hc <= (hc == 6'd7) ? 6'd0 : hc + 6'd1;
                if (hc == 6'd7) ext_clk <= ~ext_clk;
                if (hc == 6'd7) togs <= togs - 5'd1;
            end else begin
                ext_clk <= ~pol;
            end
            if (start) begin
                idx <= 3'd0;
                edges <= 5'd0;
                hc <= 6'd8;
                togs <= ext ? 5'd16 : 5'd0;
            end
        end
    end
endmodule
`default_nettype wire

// ### sync_serial_regs.vh
`ifndef SYNC_SERIAL_REGS_VH
`define SYNC_SERIAL_REGS_VH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFF_MODE     12'h000
`define OFF_CTRL     12'h004
`define OFF_BRG      12'h008
`define OFF_TXBUF    12'h00c
`define OFF_RXBUF    12'h010
`define OFF_STATUS   12'h014
`define OFF_INTSTAT  12'h018
`define OFF_INTEN    12'h01c
`define OFF_INTCLR   12'h020
// ----------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------
`define MODE_SYNC     0
`define MODE_EXTCLK   3
`define MODE_OPENDR   1
`define MODE_RTSSEL   2
`define MODE_HSDIS    4
`define MODE_CLKPOL   6
`define MODE_MSB      7
`define MODE_CLKPIN   8
`define MODE_ALTPIN   9
`define MODE_CONTRX   10
`define MODE_DATINV   11
`define MODE_IOINV    12
`define MODE_RXDIR    13
`define MODE_CLKDIR   14
`define MODE_WIDTH    15
// ----------------------------------------------------------------------
// control / status fields
// ----------------------------------------------------------------------
`define CTRL_TXEN     0
`define CTRL_RXEN     2
`define ST_TXFULL     1
`define ST_RXFULL     3
`define ST_BUSY       4
// ----------------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------------
`define INT_TXLOAD    0
`define INT_TXDONE    1
`define INT_RX        2
`define INT_OVR       3
`define INT_WIDTH     4
`define FRAME_BITS    4'h8
`endif

// ### sync_serial_shifter.v
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_regs.vh"
// 8-bit shift engine; one bit per event pulse
module sync_serial_shifter (
    input  wire       pclk,       // system clock
    input  wire       presetn,    // async reset, low
    input  wire       load,       // load new frame
    input  wire [7:0] load_data,  // frame to send
    input  wire       msb_first,  // bit order
    input  wire       launch,     // transmit edge pulse
    input  wire       sample,     // receive edge pulse
    input  wire       rx_bit,     // sampled data bit
    output reg        tx_bit,     // current output bit
    output reg  [7:0] rx_data,    // gathered frame
    output reg        done        // one-cycle frame end pulse
);
    reg [7:0] txsh;
    reg [3:0] count;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txsh    <= 8'h00;
            count   <= 4'h0;
            tx_bit  <= 1'b1;
            rx_data <= 8'h00;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                txsh   <= load_data;
                count  <= 4'h0;
                tx_bit <= 1'b1;
            end else begin
                if (launch) begin
                    // see R2
                    tx_bit <= msb_first ? txsh[7] : txsh[0];
                    txsh   <= msb_first ? {txsh[6:0], 1'b0}
                                        : {1'b0, txsh[7:1]};
                end
                if (sample) begin
                    // see R2
                    rx_data <= msb_first ? {rx_data[6:0], rx_bit}
                                         : {rx_bit, rx_data[7:1]};
                    count   <= count + 4'h1;
                    if (count == `FRAME_BITS - 4'h1)
                        done <= 1'b1; // see R12
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_regs.vh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, r;
    logic [14:0] md;
    logic        start, pol, msb, ext, use_alt;
    logic        peripheral_clock_source, handshake_pin_i;
    logic [7:0]  pb, d;
    wire  [31:0] prdata;
    wire         pready, pslverr, serial_out_pin_o, serial_out_pin_oe;
    wire         transfer_clock_pin_o, transfer_clock_pin_oe;
    wire         alt_clock_pin_o, alt_clock_pin_oe, handshake_pin_o;
    wire         handshake_pin_oe, gpio_in_valid, irq, serial_in_pin;
    wire         transfer_clock_pin_i;
    wire  [7:0]  prx;
    wire  [4:0]  pedges;
    int          error_cnt, samples_checked;
    sync_serial_mode_options u_dut (.*);
    sync_serial_partner u_far (.pclk(pclk), .presetn(presetn),
        .start(start), .pol(pol), .msb(msb), .ext(ext), .tx_byte(pb),
        .sclk_dev(use_alt ? alt_clock_pin_o : transfer_clock_pin_o),
        .sdata_dev(serial_out_pin_oe ? serial_out_pin_o : 1'b1),
        .ext_clk(transfer_clock_pin_i), .sdata(serial_in_pin),
        .rx_byte(prx), .edges(pedges));
    task close_out;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin error_cnt++; close_out(); end
    endtask
    function logic [7:0] inv(input logic [14:0] m);
        inv = (m[`MODE_IOINV] ? 8'hff : 8'h00) ^ (m[`MODE_DATINV] ? 8'hff : 8'h00);
    endfunction
    task frame(input logic [7:0] brg, tb, ptb, input logic [3:0] mk);
        int n;
        apb(1'b1, `OFF_MODE, {17'h0, md});
        apb(1'b1, `OFF_BRG, {24'h0, brg});
        apb(1'b1, `OFF_INTCLR, 32'hf);
        pol <= md[`MODE_CLKPOL];
        msb <= md[`MODE_MSB];
        ext <= md[`MODE_EXTCLK];
        use_alt <= md[`MODE_CLKPIN] & md[`MODE_ALTPIN];
        pb <= ptb;
        repeat (4) @(posedge pclk);
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        apb(1'b1, `OFF_TXBUF, {24'h0, tb});
        n = 0;
        do begin apb(1'b0, `OFF_INTSTAT, 0); n++; end
            while ((r[3:0] & mk) == 4'h0 && n < 300);
        if (n >= 300) begin error_cnt++; close_out(); end
        chk("partner rx", {24'h0, tb ^ inv(md)}, {24'h0, prx});
        if (!md[`MODE_EXTCLK]) chk("edges", 32'd16, {27'h0, pedges});
    endtask
    task rx_read(input logic [7:0] ptb, input logic armed);
        apb(1'b0, `OFF_RXBUF, 0);
        chk("rx buffer", {24'h0, ptb ^ inv(md)}, r);
        apb(1'b0, `OFF_STATUS, 0);
        chk("rx armed", {31'h0, armed}, {31'h0, r[0]});
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, start, pol, msb, ext, use_alt} = 0;
        {paddr, pwdata, pb, md} = 0;
        peripheral_clock_source = 1'b1;
        handshake_pin_i = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        void'($urandom(32'hd64c));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFF_INTSTAT, 0);
        chk("intstat reset", 32'h0, r);
        apb(1'b1, 12'h0fc, 32'hffffffff);
        apb(1'b0, 12'h0fc, 0);
        chk("unmapped", 32'h0, r);
        apb(1'b1, `OFF_CTRL, 32'h1);
        repeat (2) @(posedge pclk);
        chk("rx pin as port", 32'h1, {31'h0, gpio_in_valid});
        apb(1'b1, `OFF_CTRL, 32'h5);
        repeat (2) @(posedge pclk);
        chk("rx pin as data", 32'h0, {31'h0, gpio_in_valid});
        apb(1'b1, `OFF_INTEN, 32'h4);
        for (int i = 0; i < 6; i++) begin
            md = 15'h0001 | (15'($urandom) & 15'h18d4);
            d = 8'($urandom);
            frame(8'd5 + 8'($urandom % 5), 8'($urandom), d, 4'h4);
            chk("irq", 32'h1, {31'h0, irq});
            rx_read(d, 1'b0);
        end
        // external clock, then the alternate clock pin
        md = 15'h0019 | (15'($urandom) & 15'h0040);
        frame(8'd5, 8'h96, 8'h3c, 4'h4);
        rx_read(8'h3c, 1'b0);
        md = 15'h0311;
        frame(8'd6, 8'h1e, 8'hd2, 4'h4);
        rx_read(8'hd2, 1'b0);
        md = 15'h0011;
        frame(8'd5, 8'h11, 8'ha5, 4'h4);
        frame(8'd5, 8'h22, 8'h5a, 4'h2);
        apb(1'b0, `OFF_INTSTAT, 0);
        chk("overrun flags", 32'h8, r & 32'hc);
        rx_read(8'h5a, 1'b0);
        md = 15'h0411;
        frame(8'd7, 8'hc3, 8'h81, 4'h4);
        rx_read(8'h81, 1'b1);
        apb(1'b1, `OFF_INTEN, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, `OFF_INTEN, 32'h4);
        repeat (2) @(posedge pclk);
        chk("irq enabled", 32'h1, {31'h0, irq});
        apb(1'b1, `OFF_INTCLR, 32'h4);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        close_out();
    end
endmodule
`default_nettype wire
